// file: src/edr_ram.sv
// Embedded RAM block: registered ports, single or dual port, preload.
// Assumes synchronous fabric inputs on ref_clk; slower clocks are tick pulses.
// Functional notes
// R1: Address, data and control in registers; output data registered; all synchronous.
// R2: Selectable single-port or dual-port operation with separate read and write sections.
// R3: Data width configurable up to sixteen bits.
// R4: In dual-port mode write and read sections use their own clocks.
// R5: Each section has its own synchronous clock enable; disabled edges ignored.
// R6: The block forms its own write strobe from the write clock.
// R7: Fabric presents address, data and request meeting clock setup and hold.
// R8: Preloaded at configuration and usable as a read-only lookup table.
// R9: Dual-port allows a write and a read at the same time.
// R10: Six dedicated global inputs; four may be driven by internal logic.
// R11: Single-port uses one clock, one enable and one shared address.
`timescale 1ns/100ps
module edr_ram
  import edr_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_MAX,
  parameter int DATA_W = DATA_W_MAX,
  parameter int WR_DIV = WR_DIV_DEF,
  parameter int RD_DIV = RD_DIV_DEF,
  parameter int SP_DIV = SP_DIV_DEF
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire edr_mode_t               mode,
  input  wire logic                    rom_mode,
  input  wire logic [GLB_LINES-1:0]    glb_pin,
  input  wire logic [GLB_SHARED-1:0]   glb_int_sel,
  input  wire logic                    int_clear,
  input  wire logic                    wr_ce,
  input  wire logic                    rd_ce,
  input  wire edr_wr_req_t             wr_req,
  input  wire edr_rd_req_t             rd_req,
  output logic [DATA_W_MAX-1:0]        rd_data,
  output logic                         rd_valid,
  output logic                         ready
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [DATA_W_MAX-1:0] DMASK = DATA_W_MAX'((32'h1 << DATA_W) - 1);
  localparam logic [ADDR_W_MAX-1:0] AMAX  = ADDR_W_MAX'(DEPTH - 1);
  localparam int LOAD_MAX = 260;

  typedef enum logic { EDR_LOAD, EDR_RUN } edr_state_t;

  // Refuse sizes the array cannot serve
  if (DATA_W < 1 || DATA_W > DATA_W_MAX)
  begin : g_bad_data_w
    $error("edr_ram: DATA_W must be 1..16");
  end
  if (ADDR_W < 1 || ADDR_W > ADDR_W_MAX)
  begin : g_bad_addr_w
    $error("edr_ram: ADDR_W must be 1..8");
  end

  // ****************************************
  // Global network
  // ****************************************
  logic                  wr_tick;
  logic                  rd_tick;
  logic                  sp_tick;
  logic [GLB_LINES-1:0]  glb;

  edr_rate_div #(.DIV(WR_DIV)) u_wr_div (.ref_clk(ref_clk), .rst_n(rst_n), .tick(wr_tick));
  edr_rate_div #(.DIV(RD_DIV)) u_rd_div (.ref_clk(ref_clk), .rst_n(rst_n), .tick(rd_tick));
  edr_rate_div #(.DIV(SP_DIV)) u_sp_div (.ref_clk(ref_clk), .rst_n(rst_n), .tick(sp_tick));

  // Shared lines may be taken from internal logic
  always_comb
  begin
    glb = glb_pin;
    if (glb_int_sel[GLB_WR_CLK]) glb[GLB_WR_CLK] = wr_tick;   // see R10
    if (glb_int_sel[GLB_RD_CLK]) glb[GLB_RD_CLK] = rd_tick;   // see R10
    if (glb_int_sel[GLB_CLEAR])  glb[GLB_CLEAR]  = int_clear; // see R10
    if (glb_int_sel[GLB_SP_CLK]) glb[GLB_SP_CLK] = sp_tick;   // see R10
  end

  // ****************************************
  // Section clock edges
  // ****************************************
  logic dual;
  logic wr_edge;
  logic rd_edge;

  assign dual    = (mode == EDR_DUAL);                                         // see R2
  assign wr_edge = (dual ? glb[GLB_WR_CLK] : glb[GLB_SP_CLK]) & wr_ce;         // see R4, R5, R11
  assign rd_edge = dual ? (glb[GLB_RD_CLK] & rd_ce) : (glb[GLB_SP_CLK] & wr_ce); // see R4, R5, R11

  // ****************************************
  // Preload and port registers
  // ****************************************
  logic [DATA_W_MAX-1:0] mem [DEPTH];
  edr_state_t            state_q,    state_d;
  logic [ADDR_W_MAX-1:0] load_addr_q, load_addr_d;
  edr_wr_req_t           wr_q,       wr_d;
  logic                  wr_stb_q,   wr_stb_d;
  logic [ADDR_W_MAX-1:0] rd_addr_q,  rd_addr_d;
  logic                  rd_pend_q,  rd_pend_d;
  logic [DATA_W_MAX-1:0] rd_data_q,  rd_data_d;
  logic                  rd_valid_q, rd_valid_d;
  logic [DATA_W_MAX-1:0] rd_word;
  logic                  mem_we;
  logic [ADDR_W_MAX-1:0] mem_addr;
  logic [DATA_W_MAX-1:0] mem_wdata;

  assign rd_word = mem[rd_addr_q[ADDR_W-1:0]];

  always_comb
  begin
    state_d     = state_q;
    load_addr_d = load_addr_q;
    wr_d        = wr_q;
    wr_stb_d    = 1'b0;
    rd_addr_d   = rd_addr_q;
    rd_pend_d   = 1'b0;
    rd_data_d   = rd_data_q;
    rd_valid_d  = 1'b0;
    case (state_q)
      EDR_LOAD:
      begin
        load_addr_d = load_addr_q + ADDR_W_MAX'(1); // see R8
        if (load_addr_q == AMAX)
          state_d = EDR_RUN;
      end
      EDR_RUN:
      begin
        if (glb[GLB_RELOAD])
        begin
          state_d     = EDR_LOAD;
          load_addr_d = ADDR_RST;
        end
        if (wr_edge)
        begin
          wr_d      = wr_req;                                // see R1, R7
          wr_d.data = wr_req.data & DMASK;                   // see R3
          wr_stb_d  = wr_req.we & ~rom_mode;                 // see R6, R8
        end
        if (rd_edge)
        begin
          rd_addr_d = dual ? rd_req.addr : wr_req.addr;      // see R1, R11
          rd_pend_d = 1'b1;                                  // see R9
        end
      end
      default:
      begin
        state_d = EDR_LOAD;
      end
    endcase
    if (rd_pend_q)
    begin
      rd_data_d  = rd_word & DMASK;                          // see R1, R3
      rd_valid_d = 1'b1;
    end
    if (glb[GLB_OCLR])
      rd_data_d = DATA_RST;
    if (glb[GLB_CLEAR])
    begin
      wr_stb_d  = 1'b0;
      rd_pend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= EDR_LOAD;
      load_addr_q <= ADDR_RST;
      wr_q        <= '0;
      wr_stb_q    <= 1'b0;
      rd_addr_q   <= ADDR_RST;
      rd_pend_q   <= 1'b0;
      rd_data_q   <= DATA_RST;
      rd_valid_q  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      load_addr_q <= load_addr_d;
      wr_q        <= wr_d;
      wr_stb_q    <= wr_stb_d;
      rd_addr_q   <= rd_addr_d;
      rd_pend_q   <= rd_pend_d;
      rd_data_q   <= rd_data_d;
      rd_valid_q  <= rd_valid_d;
    end
  end

  // ****************************************
  // Memory array
  // ****************************************
  always_comb
  begin
    mem_we    = wr_stb_q;
    mem_addr  = wr_q.addr;
    mem_wdata = wr_q.data;
    if (state_q == EDR_LOAD)
    begin
      mem_we    = 1'b1;
      mem_addr  = load_addr_q;
      mem_wdata = edr_init_word(load_addr_q) & DMASK; // see R8
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mem_addr[ADDR_W-1:0]] <= mem_wdata; // see R6
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign ready    = (state_q == EDR_RUN);

  // ****************************************
  // Checks
  // ****************************************
  chk_wr_capture: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R1
    (ready && wr_edge && !glb[GLB_CLEAR]) |=> (wr_q.addr == $past(wr_req.addr)))
    else $error("write address not captured");

  chk_strobe_self: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R6
    (ready && wr_edge && wr_req.we && !rom_mode && !glb[GLB_CLEAR]) |=> wr_stb_q ##1 (!wr_stb_q || $past(wr_edge)))
    else $error("write strobe not self timed");

  chk_wr_ce_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R5
    !wr_ce |=> (!wr_stb_q && $stable(wr_q)))
    else $error("write section acted while disabled");

  chk_rd_ce_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R5
    (dual && !rd_ce) |=> $stable(rd_addr_q))
    else $error("read section acted while disabled");

  chk_rom_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R8
    (ready && rom_mode) |=> !wr_stb_q)
    else $error("write while read-only");

  chk_preload_end: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R8
    $fell(ready) || (state_q == EDR_LOAD && load_addr_q == ADDR_RST) |-> ##[1:LOAD_MAX] ready)
    else $error("preload did not finish");

  chk_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R1
    (rd_pend_q && !glb[GLB_OCLR]) |=> (rd_valid && rd_data == ($past(rd_word) & DMASK)))
    else $error("read data wrong");

  chk_width_mask: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R3
    (rd_data & ~DMASK) == '0)
    else $error("data wider than configured");

  chk_single_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R11
    (ready && !dual && wr_edge && !glb[GLB_RELOAD]) |=> (rd_addr_q == wr_q.addr && rd_pend_q == !$past(glb[GLB_CLEAR])))
    else $error("single port address not shared");

  chk_dual_both: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R4, R9
    (ready && dual && wr_edge && rd_edge && wr_req.we && !rom_mode && !glb[GLB_CLEAR]) |=> (wr_stb_q && rd_pend_q))
    else $error("simultaneous write and read lost");

endmodule

// file: src/edr_pkg.sv
// Shared types and constants of the embedded RAM block.
// Assumes a single 50 MHz ref_clk domain in the fabric.
package edr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ADDR_W_MAX = 8;
  localparam int DATA_W_MAX = 16;
  localparam int GLB_LINES  = 6;
  localparam int GLB_SHARED = 4;

  // ****************************************
  // Global line roles
  // ****************************************
  localparam int GLB_WR_CLK = 0;
  localparam int GLB_RD_CLK = 1;
  localparam int GLB_CLEAR  = 2;
  localparam int GLB_SP_CLK = 3;
  localparam int GLB_OCLR   = 4;
  localparam int GLB_RELOAD = 5;

  // ****************************************
  // Clock and default rates
  // ****************************************
  localparam int REF_CLK_HZ  = 50_000_000;
  localparam int WR_DIV_DEF  = 1;
  localparam int RD_DIV_DEF  = 2;
  localparam int SP_DIV_DEF  = 1;

  // ****************************************
  // Reset values and patterns
  // ****************************************
  localparam logic [DATA_W_MAX-1:0] DATA_RST  = 16'h0000;
  localparam logic [ADDR_W_MAX-1:0] ADDR_RST  = 8'h00;
  localparam logic [DATA_W_MAX-1:0] INIT_SALT = 16'ha500;

  typedef enum logic { EDR_SINGLE, EDR_DUAL } edr_mode_t;

  typedef struct packed {
    logic                  we;
    logic [ADDR_W_MAX-1:0] addr;
    logic [DATA_W_MAX-1:0] data;
  } edr_wr_req_t;

  typedef struct packed {
    logic [ADDR_W_MAX-1:0] addr;
  } edr_rd_req_t;

  // Preload contents for read-only use
  function automatic logic [DATA_W_MAX-1:0] edr_init_word(input logic [ADDR_W_MAX-1:0] a);
    edr_init_word = INIT_SALT ^ {a, ~a};
  endfunction

endpackage

// file: src/edr_rate_div.sv
// Divider giving a one-cycle enable pulse every DIV ref_clk cycles.
// Assumes DIV of at least one.
`timescale 1ns/100ps
module edr_rate_div
  import edr_pkg::*;
#(
  parameter int DIV = 1
)
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Refuse a divider that cannot count
  if (DIV < 1)
  begin : g_bad_div
    $error("edr_rate_div: DIV must be at least 1");
  end

  // ****************************************
  // Counter
  // ****************************************
  always_comb
  begin
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign tick = (cnt_q == LAST);

endmodule

// file: test/edr_fabric.sv
// Fabric user logic model that drives the RAM block requests.
// Assumes the block shares ref_clk; every change lands at a rising edge.
`timescale 1ns/100ps
module edr_fabric
  import edr_pkg::*;
(
  input  wire logic             ref_clk,
  output edr_mode_t             mode,
  output logic                  rom_mode,
  output logic [GLB_LINES-1:0]  glb_pin,
  output logic [GLB_SHARED-1:0] glb_int_sel,
  output logic                  int_clear,
  output logic                  wr_ce,
  output logic                  rd_ce,
  output edr_wr_req_t           wr_req,
  output edr_rd_req_t           rd_req
);
  initial
  begin
    mode        = EDR_DUAL;
    rom_mode    = 1'b0;
    glb_pin     = '0;
    glb_int_sel = '0;
    int_clear   = 1'b0;
    wr_ce       = 1'b0;
    rd_ce       = 1'b0;
    wr_req      = '0;
    rd_req      = '0;
  end

  task automatic cfg(input edr_mode_t m, input logic rom, input logic [3:0] sel, input logic clr);
    @(posedge ref_clk);
    mode        <= m;
    rom_mode    <= rom;
    glb_int_sel <= sel;
    int_clear   <= clr;
  endtask

  // One request held for one taking edge, then lines scrambled
  task automatic issue(input logic [5:0] g, input logic wce, rce, we, input logic [7:0] wa,
                       input logic [15:0] wd, input logic [7:0] ra);
    @(posedge ref_clk);
    glb_pin <= g;
    wr_ce   <= wce;
    rd_ce   <= rce;
    wr_req  <= '{we, wa, wd};
    rd_req  <= '{ra};
    @(posedge ref_clk);
    glb_pin <= '0;
    wr_ce   <= 1'b0;
    rd_ce   <= 1'b0;
    wr_req  <= '{1'b0, ~wa, ~wd};
    rd_req  <= '{~ra};
  endtask
endmodule

// file: test/edr_ram_tb.sv
// Self-checking bench of the embedded RAM block.
// Assumes the fabric model in edr_fabric drives every block input except ref_clk and rst_n.
`timescale 1ns/100ps
module edr_ram_tb
  import edr_pkg::*;
;
  localparam int AW = 4;
  localparam int DW = 12;
  logic                  ref_clk;
  logic                  rst_n;
  edr_mode_t             mode;
  logic                  rom_mode;
  logic [GLB_LINES-1:0]  glb_pin;
  logic [GLB_SHARED-1:0] glb_int_sel;
  logic                  int_clear;
  logic                  wr_ce;
  logic                  rd_ce;
  edr_wr_req_t           wr_req;
  edr_rd_req_t           rd_req;
  logic [15:0]           rd_data;
  logic                  rd_valid;
  logic                  ready;
  int                    n_mismatch;
  int                    checked;
  int                    n;

  edr_fabric i_fab (.ref_clk(ref_clk), .mode(mode), .rom_mode(rom_mode), .glb_pin(glb_pin),
    .glb_int_sel(glb_int_sel), .int_clear(int_clear), .wr_ce(wr_ce), .rd_ce(rd_ce),
    .wr_req(wr_req), .rd_req(rd_req));
  edr_ram #(.ADDR_W(AW), .DATA_W(DW)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .mode(mode),
    .rom_mode(rom_mode), .glb_pin(glb_pin), .glb_int_sel(glb_int_sel), .int_clear(int_clear),
    .wr_ce(wr_ce), .rd_ce(rd_ce), .wr_req(wr_req), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .ready(ready));

  always #10 ref_clk = ~ref_clk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] pre(input logic [7:0] a);
    pre = (INIT_SALT ^ {a, ~a}) & 16'((32'h1 << DW) - 1);
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic rd(input logic [5:0] g, input logic wce, rce, input logic [7:0] a,
                    input logic [15:0] exp, input logic vexp);
    i_fab.issue(g, wce, rce, 1'b0, a, 16'h0000, a);
    @(posedge ref_clk);
    #1;
    chk("rd_valid", {15'h0000, rd_valid}, {15'h0000, vexp});
    if (vexp)
    begin
      chk("rd_data", rd_data, exp);
      @(posedge ref_clk);
      #1;
      chk("rd_valid_end", {15'h0000, rd_valid}, 16'h0000);
    end
  endtask

  // Wait for preload to finish and check its length
  task automatic wait_load(input string what);
    n = 0;
    while (n < 300 && ready !== 1'b1)
    begin
      @(posedge ref_clk);
      n++;
      #1;
    end
    chk(what, n[15:0], 16'(1 << AW));
  endtask

  task automatic close_out;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_dual;
    i_fab.issue(6'h03, 1'b1, 1'b1, 1'b1, 8'h05, 16'hf123, 8'h06);
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    chk("rd_same_time", rd_data, pre(8'h06));
    rd(6'h02, 1'b0, 1'b1, 8'h05, 16'h0123, 1'b1);
    rd(6'h02, 1'b0, 1'b1, 8'h0f, pre(8'h0f), 1'b1);
  endtask

  task automatic t_enable;
    i_fab.issue(6'h01, 1'b0, 1'b0, 1'b1, 8'h07, 16'h0555, 8'h00);
    i_fab.issue(6'h00, 1'b1, 1'b0, 1'b1, 8'h07, 16'h0666, 8'h00);
    rd(6'h02, 1'b0, 1'b1, 8'h07, pre(8'h07), 1'b1);
    rd(6'h02, 1'b0, 1'b0, 8'h07, 16'h0000, 1'b0);
    rd(6'h00, 1'b0, 1'b1, 8'h07, 16'h0000, 1'b0);
  endtask

  task automatic t_single;
    i_fab.cfg(EDR_SINGLE, 1'b0, 4'h0, 1'b0);
    i_fab.issue(6'h08, 1'b1, 1'b0, 1'b1, 8'h09, 16'h0abc, 8'h00);
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    chk("sp_old_data", rd_data, pre(8'h09));
    rd(6'h08, 1'b1, 1'b0, 8'h09, 16'h0abc, 1'b1);
    rd(6'h08, 1'b0, 1'b1, 8'h09, 16'h0000, 1'b0);
  endtask

  task automatic t_rom_clear;
    i_fab.cfg(EDR_DUAL, 1'b1, 4'h0, 1'b0);
    i_fab.issue(6'h01, 1'b1, 1'b0, 1'b1, 8'h0a, 16'h0111, 8'h00);
    i_fab.cfg(EDR_DUAL, 1'b0, 4'h4, 1'b1);
    i_fab.issue(6'h01, 1'b1, 1'b0, 1'b1, 8'h0b, 16'h0222, 8'h00);
    i_fab.cfg(EDR_DUAL, 1'b0, 4'h0, 1'b0);
    rd(6'h02, 1'b0, 1'b1, 8'h0a, pre(8'h0a), 1'b1);
    rd(6'h02, 1'b0, 1'b1, 8'h0b, pre(8'h0b), 1'b1);
    i_fab.issue(6'h10, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000, 8'h00);
    #1;
    chk("rd_data_clr", rd_data, 16'h0000);
  endtask

  task automatic t_reload_div;
    i_fab.cfg(EDR_DUAL, 1'b0, 4'h1, 1'b0);
    i_fab.issue(6'h00, 1'b1, 1'b0, 1'b1, 8'h0c, 16'h0999, 8'h00);
    i_fab.cfg(EDR_DUAL, 1'b0, 4'h0, 1'b0);
    rd(6'h02, 1'b0, 1'b1, 8'h0c, 16'h0999, 1'b1);
    i_fab.issue(6'h20, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000, 8'h00);
    #1;
    chk("reload_ready", {15'h0000, ready}, 16'h0000);
    wait_load("reload_len");
    rd(6'h02, 1'b0, 1'b1, 8'h0c, pre(8'h0c), 1'b1);
  endtask

  initial
  begin
    ref_clk    = 1'b0;
    rst_n      = 1'b0;
    n_mismatch = 0;
    checked    = 0;
    repeat (20) @(posedge ref_clk);
    chk("rst_out", {rd_data[13:0], rd_valid, ready}, 16'h0000);
    chk("rst_data", rd_data, DATA_RST);
    rst_n <= 1'b1;
    wait_load("preload_len");
    t_dual();
    t_enable();
    t_single();
    t_rom_clear();
    t_reload_div();
    close_out();
  end

  initial
  begin
    #100_000;
    n_mismatch++;
    close_out();
  end
endmodule
